// ### dv/otpic_checker_sva.sv
/*
  Concurrent checks on the ports of the array integrity checker.
  Assumes one clock, synchronous active-low reset, bound to the top.
*/
`timescale 1ns/100ps
module otpic_checker_sva #(
  parameter int unsigned FACT_CFG_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register ports
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [3:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Check controls
  input wire logic [FACT_CFG_W-1:0] fact_cfg,
  input wire logic fact_lock,
  input wire logic [2:0] fact_crc_stored,
  input wire logic user_lock,
  input wire logic burn_cmd,
  input wire logic nvm_wr,
  input wire logic [2:0] nvm_code,
  // Status
  input wire logic offset_limit,
  input wire logic oc_init_done,
  input wire logic test_mode,
  input wire logic [7:0] health_status_reg,
  input wire logic factory_array_ok,
  input wire logic user_array_ok
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_offset_flag_low: assert property (
    offset_limit |-> ##2 !health_status_reg[1])
    else $error("offset flag not low at limit");
  a_maker_code_rw: assert property (
    reg_wr && reg_addr == 4'hD ##1 rd_addr == 4'hD && !reg_wr
    |=> rd_data == $past(reg_wdata, 2))
    else $error("maker code readback wrong");
  a_fact_clear_locked: assert property (
    $fell(factory_array_ok) |-> fact_lock)
    else $error("factory flag cleared while unlocked");
  a_user_clear_locked: assert property (
    $fell(user_array_ok) |-> user_lock)
    else $error("user flag cleared while unlocked");
  a_burn_needs_lock: assert property (
    nvm_wr |-> user_lock ##1 !nvm_wr)
    else $error("code burn without lock or too long");
  a_fact_flag_sticky: assert property (
    !factory_array_ok && fact_lock ##1 fact_lock |-> !factory_array_ok)
    else $error("factory flag left cleared state");
  a_ok_after_reset: assert property (disable iff (1'b0)
    !resetn |=> factory_array_ok && user_array_ok)
    else $error("health flags not restored by reset");
  a_unlocked_no_err: assert property (
    !fact_lock [*3] |-> factory_array_ok)
    else $error("unlocked factory check shows error");
  // Main scenarios
  c_fact_err: cover property ($fell(factory_array_ok));
  c_user_err: cover property ($fell(user_array_ok));
  c_burn: cover property (nvm_wr);
endmodule

bind otpic_checker otpic_checker_sva #(.FACT_CFG_W(FACT_CFG_W)) u_sva (.*);

// ### dv/otpic_checker_tb.sv
/*
  Self-checking bench of the array integrity checker.
  Assumes the design package and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module otpic_checker_tb;
  import otpic_pkg::*;
  // Stimulus and observed signals
  logic clock = 0, resetn = 0, reg_wr = 0, burn_cmd = 0;
  logic fact_lock = 0, user_lock = 0, offset_limit = 0;
  logic oc_init_done = 0, test_mode = 0, nvm_wr;
  logic [3:0] reg_addr = 0, rd_addr = 0;
  logic [7:0] reg_wdata = 0, fact_cfg = 0, rd_data, health_status_reg;
  logic [2:0] fact_crc_stored = 0, nvm_code, good;
  logic factory_array_ok, user_array_ok;
  logic [7:0] sh [14], q;
  logic [19:0] rows [15];
  int fails = 0, n_checks = 0, cyc = 0, n_wr = 0;
  otpic_checker dut (.clock, .resetn, .reg_wr, .reg_addr, .reg_wdata,
    .rd_addr, .rd_data, .fact_cfg, .fact_lock, .fact_crc_stored,
    .user_lock, .burn_cmd, .nvm_wr, .nvm_code, .offset_limit,
    .oc_init_done, .test_mode, .health_status_reg, .factory_array_ok,
    .user_array_ok);
  initial forever #12.5 clock = ~clock;
  // Cycle ceiling and burn pulse count
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (nvm_wr === 1'b1) n_wr <= n_wr + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      conclude;
    end
  end
  // Serial CRC x^3+x+1, seed all ones, bit 0 first
  function automatic logic [2:0] crc_of(input logic [63:0] v, input int n);
    logic [2:0] c;
    logic f;
    c = 3'h7;
    for (int i = 0; i < n; i++) begin
      f = c[2] ^ v[i];
      c = {c[1], c[0] ^ f, f};
    end
    return c;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    if (a != 4'hC && a <= 4'hD) sh[a] = d;
    @(negedge clock);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [3:0] a);
    rd_addr = a;
    @(negedge clock);
    q = rd_data;
  endtask
  task automatic conclude;
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    foreach (sh[i]) sh[i] = 8'h00;
    for (int i = 0; i < 12; i++) rows[i] = {i[3:0], 8'h31 * i[7:0], 8'h31 * i[7:0]};
    rows[12] = {4'hD, 8'h5A, 8'h5A};
    rows[13] = {4'hC, 8'hFF, 8'h57};
    rows[14] = {4'hE, 8'hFF, 8'h00};
    repeat (4) @(negedge clock);
    resetn = 1;
    rd(4'hC);
    chk("status", 8'h57, q);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk("rd_data", rows[i][7:0], q);
    end
    burn_cmd = 1;
    @(negedge clock) burn_cmd = 0;
    repeat (200) @(negedge clock);
    chk("nvm_wr unlocked", 0, n_wr);
    user_lock = 1;
    burn_cmd = 1;
    @(negedge clock) burn_cmd = 0;
    repeat (300) if (n_wr == 0) @(negedge clock);
    good = crc_of({sh[13], sh[11], sh[10], sh[9], sh[8], sh[7], sh[6], sh[5]}, 64);
    chk("nvm_code", good, nvm_code);
    repeat (150) @(negedge clock);
    chk("user ok", 1, user_array_ok);
    wr(4'h5, sh[5] ^ 8'h80);
    repeat (200) @(negedge clock);
    chk("user ok", 0, user_array_ok);
    fact_cfg = 8'h3C;
    good = crc_of({fact_cfg, sh[4], sh[3], sh[2], sh[1], sh[0]}, 48);
    fact_crc_stored = good;
    fact_lock = 1;
    repeat (150) @(negedge clock);
    chk("fact ok", 1, factory_array_ok);
    fact_crc_stored = good ^ 3'h1;
    repeat (150) @(negedge clock);
    chk("fact ok", 0, factory_array_ok);
    fact_crc_stored = good;
    offset_limit = 1;
    repeat (150) @(negedge clock);
    rd(4'hC);
    chk("status", 8'h41, q);
    fact_lock = 0;
    offset_limit = 0;
    repeat (5) @(negedge clock);
    chk("fact ok unlocked", 1, factory_array_ok);
    resetn = 0;
    @(negedge clock) resetn = 1;
    chk("user ok reset", 1, user_array_ok);
    oc_init_done = 1;
    test_mode = 1;
    repeat (3) @(negedge clock);
    rd(4'hC);
    chk("status", 8'h1F, q);
    conclude;
  end
endmodule

// ### verilog/otpic_checker.sv
/*
  Integrity checker for the one-time-programmable configuration
  arrays. Holds the shadow registers, runs a continuous CRC over the
  factory array and an error-detection code over the user array,
  stores the user code on a burn command, and keeps the health status
  register.
  Assumes the shadow loader, the programming-mode decoder and the
  signal path sit on the same clock; no input needs synchronising.
*/
`timescale 1ns/100ps
// Behaviour
// - Offset flag low at offset limit
// - Eight-bit maker code register at 0x0D
// - Factory array CRC only while locked
// - Polynomial x3+x+1, seed all ones
// - Factory CRC over 0x00-0x04 plus config
// - LSB first, ascending register order
// - Factory mismatch clears factory health flag
// - Factory CRC reads shadow registers only
// - User array checked independently, when locked and a code is burned
// - Burn with lock computes, stores user code
// - User code over 0x05-0x0B and 0x0D
// - User mismatch clears user health flag
// - User check reads shadow registers only
// - Cleared factory and user health flags stay until reset; unlocked checks read healthy
// Both checks share one serial engine design; the user code reuses
// the factory polynomial, so a burned code is only three bits wide.
// Passes run back to back, so a corrupted shadow bit is reported
// within two pass lengths plus one cycle of the corruption.
module otpic_checker
  import otpic_pkg::*;
#(
  parameter int unsigned FACT_CFG_W = OTPIC_FACT_CFG_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Shadow register write port (loader and programming mode)
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Register read port
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data,
  // Factory array shadow extras
  input wire logic [FACT_CFG_W-1:0] fact_cfg,
  input wire logic fact_lock,
  input wire logic [2:0] fact_crc_stored,
  // User array lock and programming-mode burn command
  input wire logic user_lock,
  input wire logic burn_cmd,
  // Code written to nonvolatile memory on a burn
  output logic nvm_wr,
  output logic [2:0] nvm_code,
  // Other status sources
  input wire logic offset_limit,
  input wire logic oc_init_done,
  input wire logic test_mode,
  // Health status
  output logic [7:0] health_status_reg,
  output logic factory_array_ok,
  output logic user_array_ok
);

  localparam int unsigned FACT_W = 40 + FACT_CFG_W;
  localparam int unsigned USER_W = 64;

  logic [7:0] shadow_q [OTPIC_NUM_REGS]; // Shadow copies of fuses
  logic [2:0] user_code_q; // Stored user code
  logic user_code_valid_q; // Code has been burned
  logic burn_pend_q; // Burn waiting for a pass
  logic fact_ok_q; // Sticky factory health
  logic user_ok_q; // Sticky user health
  logic offset_ok_q; // Offset health
  logic [7:0] status_q; // Assembled status register
  logic [7:0] rd_q; // Read data
  logic nvm_wr_q; // Burn strobe
  logic [2:0] nvm_code_q; // Code being burned
  logic fact_done, user_done; // End-of-pass pulses
  logic [2:0] fact_crc, user_crc; // Finished codes

  // Covered bit vectors taken from shadows, not fuses
  wire logic [FACT_W-1:0] fact_bits = {fact_cfg, shadow_q[4],
    shadow_q[3], shadow_q[2], shadow_q[1], shadow_q[0]};
  wire logic [USER_W-1:0] user_bits = {shadow_q[OTPIC_MAKER_ADDR],
    shadow_q[11], shadow_q[10], shadow_q[9], shadow_q[8],
    shadow_q[7], shadow_q[6], shadow_q[5]};

  // Enables and compare results
  wire logic fact_en = fact_lock;
  wire logic user_en = user_lock && user_code_valid_q;
  wire logic fact_bad = fact_en && fact_done &&
    (fact_crc != fact_crc_stored);
  wire logic user_bad = user_en && user_done &&
    (user_crc != user_code_q);
  wire logic user_run = user_en || burn_pend_q;
  wire logic burn_take = burn_pend_q && user_done;
  wire logic wr_ok = reg_wr && (reg_addr != OTPIC_STATUS_ADDR) &&
    (reg_addr <= OTPIC_MAKER_ADDR);

  // Status byte, unlocked checks read as healthy
  wire logic [7:0] status_d = {1'b0, ~test_mode, 1'b0,
    user_ok_q || !user_en, oc_init_done, fact_ok_q || !fact_en,
    offset_ok_q, 1'b1};
  wire logic [7:0] rd_d = (rd_addr == OTPIC_STATUS_ADDR) ? status_q :
    (rd_addr <= OTPIC_MAKER_ADDR) ? shadow_q[rd_addr] : 8'h00;

  // Factory array engine
  otpic_crc_pass #(.DATA_W(FACT_W)) u_fact (
    .clock(clock),
    .resetn(resetn),
    .run(fact_en),
    .bits(fact_bits),
    .crc_out(fact_crc),
    .done(fact_done)
  );

  // User array engine, same code
  otpic_crc_pass #(.DATA_W(USER_W)) u_user (
    .clock(clock),
    .resetn(resetn),
    .run(user_run),
    .bits(user_bits),
    .crc_out(user_crc),
    .done(user_done)
  );

  // Shadow registers, maker code included
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < OTPIC_NUM_REGS; i++) begin
        shadow_q[i] <= OTPIC_REG_RESET;
      end
    end else if (wr_ok) begin
      shadow_q[reg_addr] <= reg_wdata;
    end
  end

  // Burn: wait for the next user pass end, then store and emit code
  always_ff @(posedge clock) begin
    if (!resetn) begin
      burn_pend_q <= 1'b0;
      user_code_q <= OTPIC_CODE_RESET;
      user_code_valid_q <= 1'b0;
      nvm_wr_q <= 1'b0;
      nvm_code_q <= OTPIC_CODE_RESET;
    end else begin
      nvm_wr_q <= burn_take;
      if (burn_cmd && user_lock) begin
        burn_pend_q <= 1'b1;
      end else if (burn_take) begin
        burn_pend_q <= 1'b0;
      end
      if (burn_take) begin
        user_code_q <= user_crc;
        user_code_valid_q <= 1'b1;
        nvm_code_q <= user_crc;
      end
    end
  end

  // Sticky health flags, checked at pass end; offset flag is the inverse of offset_limit each cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fact_ok_q <= 1'b1;
      user_ok_q <= 1'b1;
      offset_ok_q <= 1'b1;
    end else begin
      if (fact_bad) begin
        fact_ok_q <= 1'b0;
      end
      if (user_bad && !burn_pend_q) begin
        user_ok_q <= 1'b0;
      end
      offset_ok_q <= ~offset_limit;
    end
  end

  // Status and read registers
  // Status is one more flop after the sticky flags, so every output
  // of the block comes straight from a register.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= OTPIC_STATUS_RESET;
      rd_q <= OTPIC_REG_RESET;
    end else begin
      status_q <= status_d;
      rd_q <= rd_d;
    end
  end

  // Outputs, all driven from flops
  assign rd_data = rd_q;
  assign health_status_reg = status_q;
  assign factory_array_ok = status_q[OTPIC_ST_FACT_BIT];
  assign user_array_ok = status_q[OTPIC_ST_USER_BIT];
  assign nvm_wr = nvm_wr_q;
  assign nvm_code = nvm_code_q;

endmodule

// ### verilog/otpic_crc_pass.sv
/*
  Serial CRC pass engine: walks a bit vector from bit 0 upward, one
  bit per clock, and reports the finished CRC with a one-cycle pulse.
  Assumes the vector is stable or slowly changing; clock and reset
  are those of the parent.
*/
`timescale 1ns/100ps
module otpic_crc_pass
  import otpic_pkg::*;
#(
  parameter int unsigned DATA_W = 64
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic run,
  // Covered bits, bit 0 enters first
  input wire logic [DATA_W-1:0] bits,
  // Result
  output logic [2:0] crc_out,
  output logic done
);

  localparam int unsigned IDX_W = $clog2(DATA_W);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DATA_W - 1);

  otpic_state_t state_q, state_d; // Engine state
  logic [IDX_W-1:0] idx_q, idx_d; // Current bit index
  logic [2:0] crc_q, crc_d; // Running CRC
  logic [2:0] res_q; // Last finished CRC
  logic done_q; // End-of-pass pulse

  // Wires for the step and the pass end
  wire logic cur_bit = bits[idx_q];
  wire logic [2:0] crc_next = otpic_crc_step(crc_q, cur_bit);
  wire logic last_bit = (idx_q == LAST_IDX);
  wire logic pass_end = (state_q == OTPIC_ST_RUN) && last_bit;

  // Next-state logic: passes follow back to back while running
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    crc_d = crc_q;
    case (state_q)
      OTPIC_ST_IDLE: begin
        // Seed fresh before every pass
        idx_d = '0;
        crc_d = OTPIC_CRC_SEED;
        if (run) begin
          state_d = OTPIC_ST_RUN;
        end
      end
      OTPIC_ST_RUN: begin
        // LSB first, ascending addresses
        if (last_bit) begin
          idx_d = '0;
          crc_d = OTPIC_CRC_SEED;
          if (!run) begin
            state_d = OTPIC_ST_IDLE;
          end
        end else begin
          idx_d = idx_q + IDX_W'(1);
          crc_d = crc_next;
        end
      end
      default: begin
        state_d = OTPIC_ST_IDLE;
        idx_d = '0;
        crc_d = OTPIC_CRC_SEED;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= OTPIC_ST_IDLE;
      idx_q <= '0;
      crc_q <= OTPIC_CRC_SEED;
      res_q <= OTPIC_CODE_RESET;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      crc_q <= crc_d;
      done_q <= pass_end; // Pulse after a complete pass
      if (pass_end) begin
        res_q <= crc_next;
      end
    end
  end

  assign crc_out = res_q;
  assign done = done_q;

endmodule

// ### verilog/otpic_pkg.sv
/*
  Shared constants of the configuration-array integrity checker:
  register offsets, status bit positions, reset values, CRC seed and
  polynomial taps.
  Assumes nothing of its surroundings; imported by both design files.
*/
package otpic_pkg;

  // Register map, one byte per address
  localparam int unsigned OTPIC_NUM_REGS = 14;
  localparam logic [3:0] OTPIC_FACT_FIRST = 4'h0;
  localparam logic [3:0] OTPIC_FACT_LAST = 4'h4;
  localparam logic [3:0] OTPIC_USER_FIRST = 4'h5;
  localparam logic [3:0] OTPIC_USER_LAST = 4'hB;
  localparam logic [3:0] OTPIC_STATUS_ADDR = 4'hC;
  localparam logic [3:0] OTPIC_MAKER_ADDR = 4'hD;

  // Health status register bit positions
  localparam int unsigned OTPIC_ST_ONE_BIT = 0;
  localparam int unsigned OTPIC_ST_OFFSET_BIT = 1;
  localparam int unsigned OTPIC_ST_FACT_BIT = 2;
  localparam int unsigned OTPIC_ST_OCINIT_BIT = 3;
  localparam int unsigned OTPIC_ST_USER_BIT = 4;
  localparam int unsigned OTPIC_ST_TEST_BIT = 6;

  // Values after reset
  localparam logic [7:0] OTPIC_REG_RESET = 8'h00;
  localparam logic [7:0] OTPIC_STATUS_RESET = 8'h57;
  localparam logic [2:0] OTPIC_CODE_RESET = 3'h0;

  // CRC: x^3 + x + 1, seeded with all ones
  localparam int unsigned OTPIC_CRC_W = 3;
  localparam logic [2:0] OTPIC_CRC_SEED = 3'h7;

  // Default width of the factory configuration field (lock excluded)
  localparam int unsigned OTPIC_FACT_CFG_W = 8;

  // Pass engine states, one-hot
  typedef enum logic [1:0] {
    OTPIC_ST_IDLE = 2'b01,
    OTPIC_ST_RUN = 2'b10
  } otpic_state_t;

  // One serial CRC step, bit enters at the high end of the polynomial
  function automatic logic [2:0] otpic_crc_step(input logic [2:0] crc,
                                                input logic din);
    logic fb;
    fb = crc[2] ^ din;
    otpic_crc_step = {crc[1], crc[0] ^ fb, fb};
  endfunction

endpackage
